/* sixio_consts.svh */
// Constants for the six-pin I/O port: register offsets, field positions, reset values.
`ifndef SIXIO_CONSTS_SVH
`define SIXIO_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SIXIO_OFS_STATUS 8'h03
`define SIXIO_OFS_PORT 8'h06
`define SIXIO_OFS_DIR 8'h10
`define SIXIO_OFS_OPTION 8'h11
`define SIXIO_OFS_BITOP 8'h12
`define SIXIO_OFS_IRQ_STAT 8'h13
`define SIXIO_OFS_IRQ_MASK 8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SIXIO_STAT_WAKE_BIT 7
`define SIXIO_OPT_WAKE_DIS_BIT 7
`define SIXIO_OPT_PULLUP_DIS_BIT 6
`define SIXIO_BITOP_SET_BIT 3
`define SIXIO_BITOP_IDX_HI 2
`define SIXIO_PIN_PROG_DATA 0
`define SIXIO_PIN_PROG_CLOCK 1
`define SIXIO_IRQ_PIN_CHANGE 0
`define SIXIO_IRQ_PORT_WRITE 1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SIXIO_DIR_RESET 6'h3f
`define SIXIO_OPTION_RESET 8'hff
`define SIXIO_LATCH_RESET 6'h00
`define SIXIO_IRQ_RESET 2'h0

`endif

/* sixio_pkg.sv */
// Types shared by the six-pin I/O port modules.
package sixio_pkg;

  // --------------------------------------------------------------------------
  // Instruction cycle phases
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SIXIO_Q1,
    SIXIO_Q2,
    SIXIO_Q3,
    SIXIO_Q4
  } sixio_phase_t;

endpackage : sixio_pkg

/* sixio_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module sixio_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins and clean levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_q
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // The first stage feeds only the second, so a metastable value never reaches logic.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_q <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end

endmodule : sixio_sync

/* sixio_phase.sv */
// Four-phase instruction cycle sequencer.
`timescale 1ns/1ps
module sixio_phase
  import sixio_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Current phase
  output sixio_phase_t phase_q
);

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= SIXIO_Q1;
    end else begin
      case (phase_q)
        SIXIO_Q1: phase_q <= SIXIO_Q2;
        SIXIO_Q2: phase_q <= SIXIO_Q3;
        SIXIO_Q3: phase_q <= SIXIO_Q4;
        SIXIO_Q4: phase_q <= SIXIO_Q1;
        default: phase_q <= SIXIO_Q1;
      endcase
    end
  end

endmodule : sixio_phase

/* sixio_port.sv */
// Six-pin general purpose I/O port with direction, options, wake flag and bit operations.
//
// Behaviour
// - Unimplemented port bits always read zero.
// - Wake flag set by pin-change reset only.
// - Bit operations read, modify, rewrite whole port.
// - Input pins rewrite their latch with pin level.
// - Output drives whatever the latch holds, except pins zero and one in programming mode (pin one is released).
// - Port write lands at cycle end.
// - Port read samples pins at cycle start.
// - Programming uses pin zero data, one clock.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "sixio_consts.svh"
module sixio_port
  import sixio_pkg::*;
#(
  parameter int PINS = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic wake_reset_cause,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Pins
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  output logic pullup_en,
  // Sleep and wake
  input wire logic sleep,
  output logic wake_req,
  // Serial programming
  input wire logic prog_mode,
  input wire logic prog_data_drive,
  input wire logic prog_data_oe,
  output logic prog_data_in,
  output logic prog_clock,
  // Interrupt
  output logic irq
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [PINS-1:0] sixio_bit_op(input logic [PINS-1:0] word,
                                                   input logic [7:0] cmd);
    logic [PINS-1:0] res;
    logic [`SIXIO_BITOP_IDX_HI:0] idx;
    res = word;
    idx = cmd[`SIXIO_BITOP_IDX_HI:0];
    if (int'(idx) < PINS) begin
      res[idx] = cmd[`SIXIO_BITOP_SET_BIT];
    end
    return res;
  endfunction : sixio_bit_op

  function automatic logic sixio_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : sixio_hit

  // --------------------------------------------------------------------------
  // Phase and pin sampling
  // --------------------------------------------------------------------------
  sixio_phase_t phase;
  logic [PINS-1:0] pin_level;
  logic [PINS-1:0] pin_prev_q;
  logic [PINS-1:0] snap_q;

  sixio_phase u_phase (
    .clk(clk),
    .rst(rst),
    .phase_q(phase)
  );

  sixio_sync #(.WIDTH(PINS)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(pin_in),
    .level_q(pin_level)
  );

  // Pins are captured only in the first phase, so a read just after a write
  // may still see the old level; software must leave a gap.
  always_ff @(posedge clk) begin
    if (rst) begin
      snap_q <= '0;
    end else if (phase == SIXIO_Q1) begin
      snap_q <= pin_level;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_prev_q <= '0;
    end else begin
      pin_prev_q <= pin_level;
    end
  end

  // --------------------------------------------------------------------------
  // Register strobes
  // --------------------------------------------------------------------------
  logic wr_port;
  logic wr_bitop;
  logic wr_dir;
  logic wr_option;
  logic wr_irq_stat;
  logic wr_irq_mask;

  assign wr_port = wr && sixio_hit(addr, `SIXIO_OFS_PORT);
  assign wr_bitop = wr && sixio_hit(addr, `SIXIO_OFS_BITOP);
  assign wr_dir = wr && sixio_hit(addr, `SIXIO_OFS_DIR);
  assign wr_option = wr && sixio_hit(addr, `SIXIO_OFS_OPTION);
  assign wr_irq_stat = wr && sixio_hit(addr, `SIXIO_OFS_IRQ_STAT);
  assign wr_irq_mask = wr && sixio_hit(addr, `SIXIO_OFS_IRQ_MASK);

  // --------------------------------------------------------------------------
  // Pending port write
  // --------------------------------------------------------------------------
  // A write or bit operation is held until the last phase; a later request in
  // the same instruction cycle replaces an earlier one.
  logic pend_q;
  logic pend_bitop_q;
  logic [7:0] pend_data_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= 1'b0;
      pend_bitop_q <= 1'b0;
      pend_data_q <= 8'h00;
    end else if (wr_port || wr_bitop) begin
      pend_q <= 1'b1;
      pend_bitop_q <= wr_bitop;
      pend_data_q <= wdata;
    end else if (phase == SIXIO_Q4) begin
      pend_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Output latches
  // --------------------------------------------------------------------------
  logic [PINS-1:0] latch_q;
  logic latch_load;

  assign latch_load = pend_q && (phase == SIXIO_Q4);

  // A bit operation starts from the sampled pins, not from the latch, so an
  // input pin gets its own pin level written into its latch.
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_q <= `SIXIO_LATCH_RESET;
    end else if (latch_load) begin
      if (pend_bitop_q) begin
        latch_q <= sixio_bit_op(snap_q, pend_data_q);
      end else begin
        latch_q <= pend_data_q[PINS-1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Direction and option registers
  // --------------------------------------------------------------------------
  logic [PINS-1:0] dir_q;
  logic [7:0] option_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      dir_q <= `SIXIO_DIR_RESET;
    end else if (wr_dir) begin
      dir_q <= wdata[PINS-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      option_q <= `SIXIO_OPTION_RESET;
    end else if (wr_option) begin
      option_q <= wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  // A pin turned to output drives the latch as it stands, including any pin
  // level left there by an earlier bit operation.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= latch_q;
      pin_oe <= ~dir_q;
      if (prog_mode) begin
        pin_out[`SIXIO_PIN_PROG_DATA] <= prog_data_drive;
        pin_oe[`SIXIO_PIN_PROG_DATA] <= prog_data_oe;
        pin_oe[`SIXIO_PIN_PROG_CLOCK] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prog_data_in <= 1'b0;
      prog_clock <= 1'b0;
    end else begin
      prog_data_in <= prog_mode && pin_level[`SIXIO_PIN_PROG_DATA];
      prog_clock <= prog_mode && pin_level[`SIXIO_PIN_PROG_CLOCK];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pullup_en <= 1'b0;
    end else begin
      pullup_en <= ~option_q[`SIXIO_OPT_PULLUP_DIS_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Wake on pin change
  // --------------------------------------------------------------------------
  logic [PINS-1:0] in_change;

  assign in_change = (pin_level ^ pin_prev_q) & dir_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= sleep && !option_q[`SIXIO_OPT_WAKE_DIS_BIT] && (|in_change);
    end
  end

  // The flag is caught at the synchronous reset from the cause input and is
  // left alone otherwise.
  logic wake_flag_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      wake_flag_q <= wake_reset_cause;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status and mask
  // --------------------------------------------------------------------------
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_event;

  assign irq_event = {latch_load, |in_change};

  // A new event wins over a write-one clear in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_q <= `SIXIO_IRQ_RESET;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_irq_stat ? wdata[1:0] : 2'h0)) | irq_event;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_q <= `SIXIO_IRQ_RESET;
    end else if (wr_irq_mask) begin
      irq_mask_q <= wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Direction and option are write-only and read as zero, like unmapped offsets.
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    case (addr)
      `SIXIO_OFS_PORT: rd_mux = {{(8 - PINS){1'b0}}, snap_q};
      `SIXIO_OFS_STATUS: rd_mux[`SIXIO_STAT_WAKE_BIT] = wake_flag_q;
      `SIXIO_OFS_IRQ_STAT: rd_mux = {6'h00, irq_stat_q};
      `SIXIO_OFS_IRQ_MASK: rd_mux = {6'h00, irq_mask_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : sixio_port

/* sixio_port_assertions.sv */
// Port-level assertions for the six-pin I/O port.
`timescale 1ns/1ps
module sixio_port_assertions #(
  parameter int PINS = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic wake_reset_cause,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Pins, wake, programming, interrupt
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic sleep,
  input wire logic wake_req,
  input wire logic prog_mode,
  input wire logic prog_data_in,
  input wire logic prog_clock,
  input wire logic irq
);
  // --------------------------------------------------------------------------
  // Shadow of the phase counter and of the reset cause
  // --------------------------------------------------------------------------
  logic [1:0] ph_q;
  logic wake_q;
  always_ff @(posedge clk) begin
    ph_q <= rst ? 2'h0 : ph_q + 2'h1;
    if (rst) begin
      wake_q <= wake_reset_cause;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_read(a);
    rd && addr == a;
  endsequence

  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_port_upper: assert property (s_read(8'h06) |=> rdata[7:6] == 2'h0)
    else $error("unimplemented port bits not zero");
  a_status_wake: assert property (s_read(8'h03) |=> rdata == {wake_q, 7'h00})
    else $error("wake flag does not match reset cause");
  a_dir_drives: assert property (wr && addr == 8'h10 && !prog_mode ##1 !(wr && addr == 8'h10) && !prog_mode
    |=> pin_oe == ~$past(wdata[PINS-1:0], 2))
    else $error("output enable does not follow direction");
  a_out_phase: assert property (!prog_mode && !$past(prog_mode) && pin_out != $past(pin_out) |-> ph_q == 2'h1)
    else $error("pin output changed outside cycle end");
  a_irq_masked: assert property (wr && addr == 8'h14 && wdata[1:0] == 2'h0 |-> ##2 !irq)
    else $error("interrupt high with all sources masked");
  a_prog_quiet: assert property (!prog_mode && !$past(prog_mode) |-> !prog_clock && !prog_data_in)
    else $error("programming outputs active outside programming");
  a_prog_clk_in: assert property (prog_mode && $past(prog_mode) |-> !pin_oe[1])
    else $error("programming clock pin driven");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  a_wake_awake: assert property (!sleep [*2] |-> !wake_req)
    else $error("wake request while awake");
endmodule : sixio_port_assertions

bind sixio_port sixio_port_assertions #(.PINS(PINS)) chk (.clk, .rst, .wake_reset_cause, .addr, .wdata, .wr,
  .rd, .rdata, .pin_out, .pin_oe, .sleep, .wake_req, .prog_mode, .prog_data_in, .prog_clock, .irq);

/* sixio_pins_model.sv */
// Behavioural model of the circuits wired to the port pins.
`timescale 1ns/1ps
module sixio_pins_model #(
  parameter int PINS = 6
) (
  // Device side
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic pullup_en,
  // Outside drivers
  input wire logic [PINS-1:0] ext_val,
  input wire logic [PINS-1:0] ext_en,
  // Resolved levels
  output logic [PINS-1:0] pin_in
);
  // A floating pin reads high while pull-ups are on, else shows the inverse of the device latch, so a stale value is not mistaken for a match.
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else begin
        pin_in[i] = pullup_en | ~pin_out[i];
      end
    end
  end
endmodule : sixio_pins_model

/* six_pin_io_port_test.sv */
// Self-checking testbench for the six-pin I/O port.
`timescale 1ns/1ps
module six_pin_io_port_test;
  import sixio_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] e;} sixio_row_t;
  logic clk, rst, wake_reset_cause, wr, rd, pullup_en, sleep, wake_req, irq;
  logic prog_mode, prog_data_drive, prog_data_oe, prog_data_in, prog_clock;
  logic [7:0] addr, wdata, rdata;
  logic [5:0] pin_in, pin_out, pin_oe, ext_val, ext_en;
  int n_errors = 0;
  int checks_done = 0;
  sixio_row_t rows [6] = '{'{8'h06, 8'h2a}, '{8'h03, 8'h00}, '{8'h10, 8'h00}, '{8'h11, 8'h00},
    '{8'h20, 8'h00}, '{8'h14, 8'h00}};

  sixio_port uut (.clk(clk), .rst(rst), .wake_reset_cause(wake_reset_cause), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .sleep(sleep), .wake_req(wake_req), .prog_mode(prog_mode),
    .prog_data_drive(prog_data_drive), .prog_data_oe(prog_data_oe), .prog_data_in(prog_data_in),
    .prog_clock(prog_clock), .irq(irq));
  sixio_pins_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));

  // --------------------------------------------------------------------------
  // Bus and check helpers
  // --------------------------------------------------------------------------
  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(logic [7:0] a, logic [7:0] e, string name);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(name, e, rdata);
    @(posedge clk);
  endtask : rd_reg

  task automatic do_reset(logic cause);
    rst <= 1'b1;
    wake_reset_cause <= cause;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : do_reset

  // Outside drivers must stay off every pin that the port drives, or the pin currents fight.
  always @(negedge clk) begin
    if (!rst && (ext_en & pin_oe) !== 6'h00) check("pin_contention", 8'h00, {2'h0, ext_en & pin_oe});
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // --------------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    wake_reset_cause = 1'b0;
    {addr, wdata, wr, rd, sleep, prog_mode, prog_data_drive, prog_data_oe} = '0;
    ext_val = 6'h2a;
    ext_en = 6'h3f;
    do_reset(1'b0);
    foreach (rows[i]) rd_reg(rows[i].a, rows[i].e, "reg_read");
    $display("register defaults done");
    wr_reg(8'h06, 8'h05);
    ext_en <= 6'h38;
    wr_reg(8'h10, 8'h38);
    repeat (12) @(posedge clk);
    check("pin_oe", 8'h07, {2'h0, pin_oe});
    rd_reg(8'h06, 8'h2d, "port_mixed");
    $display("direction test done");
    // Clearing bit 0 rewrites the input pins with their levels, so pins 5 and 3 come back high.
    wr_reg(8'h12, 8'h00);
    repeat (8) @(posedge clk);
    ext_en <= 6'h00;
    wr_reg(8'h10, 8'h00);
    repeat (12) @(posedge clk);
    check("pin_out", 8'h2c, {2'h0, pin_out});
    $display("read-modify-write test done");
    wr_reg(8'h06, 8'h15);
    rd_reg(8'h06, 8'h2c, "port_early");
    repeat (12) @(posedge clk);
    rd_reg(8'h06, 8'h15, "port_late");
    wr_reg(8'h12, 8'h09);
    repeat (16) @(posedge clk);
    rd_reg(8'h06, 8'h17, "port_bitset");
    $display("successive access test done");
    wr_reg(8'h14, 8'h02);
    @(posedge clk);
    check("irq_on", 8'h01, {7'h0, irq});
    wr_reg(8'h13, 8'h03);
    @(posedge clk);
    check("irq_off", 8'h00, {7'h0, irq});
    rd_reg(8'h13, 8'h00, "irq_stat");
    wr_reg(8'h14, 8'h00);
    $display("interrupt test done");
    wr_reg(8'h10, 8'h3f);
    ext_en <= 6'h3f;
    do_reset(1'b1);
    rd_reg(8'h03, 8'h80, "status_wake");
    $display("wake reset test done");
    wr_reg(8'h11, 8'h3f);
    sleep <= 1'b1;
    repeat (8) @(posedge clk);
    check("pullup_en", 8'h01, {7'h0, pullup_en});
    ext_val <= 6'h2b;
    for (int k = 0; k < 16 && wake_req !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check("wake_req", 8'h01, {7'h0, wake_req});
    sleep <= 1'b0;
    $display("pin change wake test done");
    prog_mode <= 1'b1;
    repeat (8) @(posedge clk);
    check("prog_in", 8'h03, {6'h0, prog_clock, prog_data_in});
    ext_en <= 6'h3e;
    prog_data_oe <= 1'b1;
    repeat (8) @(posedge clk);
    check("prog_pin0", 8'h04, {5'h0, pin_oe[0], pin_out[0], prog_data_in});
    $display("programming test done");
    tally_and_finish();
  end
endmodule : six_pin_io_port_test
